// ### auto_gain_window_control.sv
/*
 Automatic gain control over a programmable statistics window, with two
 indirectly addressed windows and a plain register port.
 Assumes pixel strobes arrive from another clock domain as levels held for
 at least three core_clk cycles per pixel, and software keeps the window
 inside the sensor.
*/
// What this block does
// - Windows reset to full sensor resolution.
// - Offsets are first column/line; sizes set extent.
// - Offsets and sizes accepted in single steps.
// - Binned mode still counts plain columns and lines.
// - Selector routes offset and size writes.
// - Step gain within limits toward target.
// - Use window one; once and continuous modes.
// - No overlap means gain holds its value.
// - Target clamped to 50 through 205.
// - Target is always an 8-bit gray level.
// - Gain limit range from format, binning, restriction.
// - Once mode gives up after 30 frames.
// - Continuous mode adjusts on every frame with overlap.
// - Only overlap pixels feed the average.
// - Switching off keeps last automatic gain.
`timescale 1ns/1ps
`default_nettype none
`include "agw_map.svh"
module auto_gain_window_control #(
   parameter int CW = 12,
   parameter logic [11:0] SENSOR_COLS = 12'h293,
   parameter logic [11:0] SENSOR_LINES = 12'h1EE
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdata,
   input wire logic pixFrameStart,
   input wire logic pixFrameEnd,
   input wire logic pixLineStart,
   input wire logic pixValid,
   input wire logic pixWide,
   input wire logic [11:0] pixData,
   output logic [11:0] gainOut,
   output agw_pkg::agw_mode_type gainModeOut
);
   import agw_pkg::*;

   // ---------------------------------------------------------------
   // Register state.
   // ---------------------------------------------------------------
   logic winSel_q;
   logic [CW-1:0] colStart_q [2];
   logic [CW-1:0] lineStart_q [2];
   logic [CW-1:0] cols_q [2];
   logic [CW-1:0] lines_q [2];
   logic [CW-1:0] imgColStart_q, imgLineStart_q, imgCols_q, imgLines_q;
   logic [11:0] gainMin_q, gainMax_q, gain_q;
   logic [7:0] target_q;
   logic binning_q, wideOff_q, profile_q, assignOne_q;
   agw_mode_type mode_q;
   logic [4:0] tries_q;
   logic [7:0] avg_q;
   logic [11:0] limLo, limHi;

   // ---------------------------------------------------------------
   // Pixel strobe synchronisers, two flip-flops each.
   // ---------------------------------------------------------------
   logic [4:0] syncA_q, syncB_q, syncC_q;
   logic [11:0] pixA_q, pixB_q;
   logic pixWideA_q, pixWideB_q;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         syncA_q <= '0;
         syncB_q <= '0;
         syncC_q <= '0;
         pixA_q <= '0;
         pixB_q <= '0;
         pixWideA_q <= 1'b0;
         pixWideB_q <= 1'b0;
      end
      else
      begin
         syncA_q <= {pixWide, pixFrameStart, pixFrameEnd, pixLineStart, pixValid};
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         pixA_q <= pixData;
         pixB_q <= pixA_q;
         pixWideA_q <= pixWide;
         pixWideB_q <= pixWideA_q;
      end
   end

   // Edge strobes taken from the second stage and its delayed copy.
   logic evFrameStart, evFrameEnd, evLineStart, evPix;
   assign evPix = syncB_q[0] & ~syncC_q[0];
   assign evLineStart = syncB_q[1] & ~syncC_q[1];
   assign evFrameEnd = syncB_q[2] & ~syncC_q[2];
   assign evFrameStart = syncB_q[3] & ~syncC_q[3];

   // Wide pixels are scaled to 8 bits so the target means one gray level.
   logic [11:0] pixGray;
   assign pixGray = pixWideB_q ? {4'h0, pixB_q[11:4]} : {4'h0, pixB_q[7:0]};

   // ---------------------------------------------------------------
   // Window one intersected with the image window.
   // ---------------------------------------------------------------
   logic [CW:0] wEnd, iEnd;
   logic [CW-1:0] isLo, isHi, ilLo, ilHi;
   logic overlap;
   always_comb
   begin
      wEnd = {1'b0, colStart_q[0]} + {1'b0, cols_q[0]};
      iEnd = {1'b0, imgColStart_q} + {1'b0, imgCols_q};
      isLo = (colStart_q[0] > imgColStart_q) ? colStart_q[0] : imgColStart_q;
      isHi = (wEnd < iEnd) ? wEnd[CW-1:0] : iEnd[CW-1:0];
   end
   logic [CW:0] wlEnd, ilEnd;
   always_comb
   begin
      wlEnd = {1'b0, lineStart_q[0]} + {1'b0, lines_q[0]};
      ilEnd = {1'b0, imgLineStart_q} + {1'b0, imgLines_q};
      ilLo = (lineStart_q[0] > imgLineStart_q) ? lineStart_q[0] : imgLineStart_q;
      ilHi = (wlEnd < ilEnd) ? wlEnd[CW-1:0] : ilEnd[CW-1:0];
   end
   assign overlap = (isLo < isHi) && (ilLo < ilHi) && assignOne_q;

   // ---------------------------------------------------------------
   // Statistics path and average.
   // ---------------------------------------------------------------
   agw_stats_if stats ();
   agw_accum #(.PW(12), .CW(CW)) u_accum (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .frameStart(evFrameStart),
      .frameEnd(evFrameEnd),
      .lineStart(evLineStart),
      .pixValid(evPix),
      .pixData(pixGray),
      .winColLo(isLo),
      .winColHi(isHi),
      .winLineLo(ilLo),
      .winLineHi(ilHi),
      .stats(stats.src)
   );

   logic [31:0] quot;
   logic divDone;
   logic divStart;
   assign divStart = stats.done && (stats.count != 20'h0);
   agw_divide #(.NW(32), .DW(20)) u_div (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(divStart),
      .numer(stats.sum),
      .denom(stats.count),
      .quot(quot),
      .done(divDone)
   );

   // Allowed limit range follows format, binning and restriction switch.
   always_comb
   begin
      limLo = `AGW_GAIN_NARROW_MIN;
      if (wideOff_q)
         limHi = `AGW_GAIN_WIDE_MAX;
      else if (binning_q)
         limHi = `AGW_GAIN_BIN_MAX;
      else if (pixWideB_q)
         limHi = `AGW_GAIN_BIN_MAX;
      else
         limHi = `AGW_GAIN_NARROW_MAX;
   end

   // ---------------------------------------------------------------
   // Register writes; window fields go through the selector.
   // ---------------------------------------------------------------
   logic [CW-1:0] wv;
   assign wv = regWdata[CW-1:0];
   logic [11:0] wClamp;
   assign wClamp = (regWdata[11:0] < limLo) ? limLo : ((regWdata[11:0] > limHi) ? limHi : regWdata[11:0]);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         winSel_q <= 1'b0;
         for (int i = 0; i < 2; i++)
         begin
            colStart_q[i] <= '0;
            lineStart_q[i] <= '0;
            cols_q[i] <= SENSOR_COLS;
            lines_q[i] <= SENSOR_LINES;
         end
         imgColStart_q <= '0;
         imgLineStart_q <= '0;
         imgCols_q <= SENSOR_COLS;
         imgLines_q <= SENSOR_LINES;
         gainMin_q <= `AGW_GAIN_NARROW_MIN;
         gainMax_q <= `AGW_GAIN_NARROW_MAX;
         target_q <= `AGW_TARGET_RESET;
         binning_q <= 1'b0;
         wideOff_q <= 1'b0;
         profile_q <= 1'b0;
         assignOne_q <= 1'b1;
      end
      else if (regWr)
      begin
         if (regAddr == `AGW_REG_WIN_SELECT)
            winSel_q <= regWdata[0];
         else if (regAddr == `AGW_REG_COL_START)
            colStart_q[winSel_q] <= wv;
         else if (regAddr == `AGW_REG_LINE_START)
            lineStart_q[winSel_q] <= wv;
         else if (regAddr == `AGW_REG_COLS)
            cols_q[winSel_q] <= wv;
         else if (regAddr == `AGW_REG_LINES)
            lines_q[winSel_q] <= wv;
         else if (regAddr == `AGW_REG_GAIN_MIN)
            gainMin_q <= wClamp;
         else if (regAddr == `AGW_REG_GAIN_MAX)
            gainMax_q <= wClamp;
         else if (regAddr == `AGW_REG_TARGET)
            target_q <= (regWdata[7:0] < `AGW_TARGET_MIN) ? `AGW_TARGET_MIN :
                        ((regWdata[7:0] > `AGW_TARGET_MAX) ? `AGW_TARGET_MAX : regWdata[7:0]);
         else if (regAddr == `AGW_REG_IMG_COL_START)
            imgColStart_q <= wv;
         else if (regAddr == `AGW_REG_IMG_LINE_START)
            imgLineStart_q <= wv;
         else if (regAddr == `AGW_REG_IMG_COLS)
            imgCols_q <= wv;
         else if (regAddr == `AGW_REG_IMG_LINES)
            imgLines_q <= wv;
         else if (regAddr == `AGW_REG_CONFIG)
         begin
            binning_q <= regWdata[`AGW_CFG_BIN_BIT];
            wideOff_q <= regWdata[`AGW_CFG_WIDE_BIT];
            profile_q <= regWdata[`AGW_CFG_PROFILE_BIT];
            assignOne_q <= regWdata[`AGW_CFG_ASSIGN_BIT];
         end
      end
   end

   // ---------------------------------------------------------------
   // Mode, gain stepping and once-mode frame budget.
   // ---------------------------------------------------------------
   logic [7:0] avgNow;
   assign avgNow = (quot > 32'h0000_00FF) ? 8'hFF : quot[7:0];
   logic modeWr;
   assign modeWr = regWr && (regAddr == `AGW_REG_GAIN_MODE);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= AGW_OFF;
         gain_q <= `AGW_GAIN_RESET;
         tries_q <= '0;
         avg_q <= '0;
      end
      else if (modeWr)
      begin
         // The profile needs continuous mode, so once is upgraded when it is set.
         if (regWdata[1:0] == AGW_ONCE && profile_q)
            mode_q <= AGW_CONT;
         else if (regWdata[1:0] == AGW_ONCE)
            mode_q <= AGW_ONCE;
         else if (regWdata[1:0] == AGW_CONT)
            mode_q <= AGW_CONT;
         else
            mode_q <= AGW_OFF;
         tries_q <= '0;
      end
      else if (regWr && regAddr == `AGW_REG_GAIN_VALUE && mode_q == AGW_OFF)
      begin
         gain_q <= regWdata[11:0];
      end
      else if (divDone)
      begin
         avg_q <= avgNow;
         if (mode_q != AGW_OFF && overlap)
         begin
            if (avgNow < target_q && gain_q < gainMax_q)
               gain_q <= gain_q + `AGW_GAIN_STEP;
            else if (avgNow > target_q && gain_q > gainMin_q)
               gain_q <= gain_q - `AGW_GAIN_STEP;
            else if (gain_q > gainMax_q)
               gain_q <= gainMax_q;
            else if (gain_q < gainMin_q)
               gain_q <= gainMin_q;
            if (mode_q == AGW_ONCE)
            begin
               tries_q <= tries_q + 1'b1;
               if (avgNow == target_q || tries_q == `AGW_ONCE_FRAMES - 5'h01)
                  mode_q <= AGW_OFF;
            end
         end
      end
   end

   // Output gain: registered gain_q, held unchanged when window one misses the image.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gainOut <= `AGW_GAIN_RESET;
         gainModeOut <= AGW_OFF;
      end
      else
      begin
         gainOut <= gain_q;
         gainModeOut <= mode_q;
      end
   end

   // ---------------------------------------------------------------
   // Read port, data valid one cycle after the strobe.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdata <= '0;
      else if (!regRd)
         regRdata <= '0;
      else if (regAddr == `AGW_REG_WIN_SELECT)
         regRdata <= {15'h0, winSel_q};
      else if (regAddr == `AGW_REG_COL_START)
         regRdata <= 16'(colStart_q[winSel_q]);
      else if (regAddr == `AGW_REG_LINE_START)
         regRdata <= 16'(lineStart_q[winSel_q]);
      else if (regAddr == `AGW_REG_COLS)
         regRdata <= 16'(cols_q[winSel_q]);
      else if (regAddr == `AGW_REG_LINES)
         regRdata <= 16'(lines_q[winSel_q]);
      else if (regAddr == `AGW_REG_GAIN_MODE)
         regRdata <= {14'h0, mode_q};
      else if (regAddr == `AGW_REG_GAIN_VALUE)
         regRdata <= {4'h0, gain_q};
      else if (regAddr == `AGW_REG_GAIN_MIN)
         regRdata <= {4'h0, gainMin_q};
      else if (regAddr == `AGW_REG_GAIN_MAX)
         regRdata <= {4'h0, gainMax_q};
      else if (regAddr == `AGW_REG_TARGET)
         regRdata <= {8'h0, target_q};
      else if (regAddr == `AGW_REG_IMG_COL_START)
         regRdata <= 16'(imgColStart_q);
      else if (regAddr == `AGW_REG_IMG_LINE_START)
         regRdata <= 16'(imgLineStart_q);
      else if (regAddr == `AGW_REG_IMG_COLS)
         regRdata <= 16'(imgCols_q);
      else if (regAddr == `AGW_REG_IMG_LINES)
         regRdata <= 16'(imgLines_q);
      else if (regAddr == `AGW_REG_CONFIG)
         regRdata <= {12'h0, assignOne_q, profile_q, wideOff_q, binning_q};
      else if (regAddr == `AGW_REG_STATUS)
         regRdata <= {10'h0, tries_q, overlap};
      else if (regAddr == `AGW_REG_AVERAGE)
         regRdata <= {8'h0, avg_q};
      else if (regAddr == `AGW_REG_GAIN_LIMITS)
         regRdata <= {limHi[11:4], limLo[11:4]};
      else
         regRdata <= 16'h0000;
   end
endmodule
`default_nettype wire

// ### agw_map.svh
/*
 Register map, field positions and counts of the gain window block.
 Assumes inclusion by bare name.
*/
`ifndef AGW_MAP_SVH
`define AGW_MAP_SVH

// ---------------------------------------------------------------
// Register offsets (8-bit register index).
// ---------------------------------------------------------------
`define AGW_REG_WIN_SELECT 8'h00
`define AGW_REG_COL_START 8'h01
`define AGW_REG_LINE_START 8'h02
`define AGW_REG_COLS 8'h03
`define AGW_REG_LINES 8'h04
`define AGW_REG_GAIN_MODE 8'h05
`define AGW_REG_GAIN_VALUE 8'h06
`define AGW_REG_GAIN_MIN 8'h07
`define AGW_REG_GAIN_MAX 8'h08
`define AGW_REG_TARGET 8'h09
`define AGW_REG_IMG_COL_START 8'h0A
`define AGW_REG_IMG_LINE_START 8'h0B
`define AGW_REG_IMG_COLS 8'h0C
`define AGW_REG_IMG_LINES 8'h0D
`define AGW_REG_CONFIG 8'h0E
`define AGW_REG_STATUS 8'h0F
`define AGW_REG_AVERAGE 8'h10
`define AGW_REG_GAIN_LIMITS 8'h11

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define AGW_CFG_BIN_BIT 0
`define AGW_CFG_WIDE_BIT 1
`define AGW_CFG_PROFILE_BIT 2
`define AGW_CFG_ASSIGN_BIT 3

// ---------------------------------------------------------------
// Values and counts.
// ---------------------------------------------------------------
`define AGW_TARGET_MIN 8'h32
`define AGW_TARGET_MAX 8'hCD
`define AGW_TARGET_RESET 8'h80
`define AGW_ONCE_FRAMES 5'h1E
`define AGW_GAIN_STEP 12'h001
`define AGW_GAIN_NARROW_MIN 12'h000
`define AGW_GAIN_NARROW_MAX 12'h0FF
`define AGW_GAIN_WIDE_MAX 12'hFFF
`define AGW_GAIN_BIN_MAX 12'h1FF
`define AGW_GAIN_RESET 12'h000

`endif

// ### agw_pkg.sv
/*
 Types shared by the automatic gain window control files.
 Assumes agw_map.svh is reachable by bare name.
*/
package agw_pkg;
   typedef enum logic [1:0] {AGW_OFF = 2'h0, AGW_ONCE = 2'h1, AGW_CONT = 2'h2} agw_mode_type;
   typedef enum logic [1:0] {AGW_IDLE = 2'h0, AGW_ACCUM = 2'h1, AGW_EVAL = 2'h3} agw_state_type;
endpackage

// ### agw_stats_if.sv
/*
 Interface carrying the frame statistics from the accumulator to the top.
 Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface agw_stats_if;
   logic [31:0] sum;
   logic [19:0] count;
   logic done;
   modport src (output sum, output count, output done);
   modport dst (input sum, input count, input done);
endinterface
`default_nettype wire

// ### agw_accum.sv
/*
 Per-frame gray level sum over the window overlap.
 Assumes synchronised strobes on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module agw_accum #(parameter int PW = 12, parameter int CW = 12)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic lineStart,
   input wire logic pixValid,
   input wire logic [PW-1:0] pixData,
   input wire logic [CW-1:0] winColLo,
   input wire logic [CW-1:0] winColHi,
   input wire logic [CW-1:0] winLineLo,
   input wire logic [CW-1:0] winLineHi,
   agw_stats_if.src stats
);
   logic [CW-1:0] col_q;
   logic [CW-1:0] line_q;
   logic inWin;

   // Window bounds are pre-intersected by the top, inclusive low, exclusive high.
   assign inWin = (col_q >= winColLo) && (col_q < winColHi) && (line_q >= winLineLo) && (line_q < winLineHi);

   // ---------------------------------------------------------------
   // Position counters, in plain columns and lines whatever the binning setting.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         col_q <= '0;
         line_q <= '0;
      end
      else if (frameStart)
      begin
         col_q <= '0;
         line_q <= '0;
      end
      else if (lineStart)
      begin
         col_q <= '0;
         line_q <= line_q + 1'b1;
      end
      else if (pixValid)
      begin
         col_q <= col_q + 1'b1;
      end
   end

   // Sum and count only overlapping pixels; result published at frame end.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stats.sum <= '0;
         stats.count <= '0;
         stats.done <= 1'b0;
      end
      else
      begin
         stats.done <= frameEnd;
         if (frameStart)
         begin
            stats.sum <= '0;
            stats.count <= '0;
         end
         else if (pixValid && inWin && !stats.done)
         begin
            stats.sum <= stats.sum + 32'(pixData);
            stats.count <= stats.count + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### agw_divide.sv
/*
 Serial divider for the frame average, one bit per clock.
 Assumes a one-cycle start and a nonzero divisor.
*/
`timescale 1ns/1ps
`default_nettype none
module agw_divide #(parameter int NW = 32, parameter int DW = 20)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [NW-1:0] numer,
   input wire logic [DW-1:0] denom,
   output logic [NW-1:0] quot,
   output logic done
);
   logic [NW-1:0] num_q;
   logic [DW:0] rem_q;
   logic [5:0] cnt_q;
   logic busy_q;
   logic [DW:0] trial;

   assign trial = {rem_q[DW-1:0], num_q[NW-1]} - {1'b0, denom};

   // Restoring division keeps the area small; a frame gives plenty of time.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         num_q <= '0;
         rem_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         quot <= '0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            num_q <= numer;
            rem_q <= '0;
            cnt_q <= 6'(NW);
            busy_q <= 1'b1;
         end
         else if (busy_q)
         begin
            if (!trial[DW])
            begin
               rem_q <= trial;
            end
            else
            begin
               rem_q <= {rem_q[DW-1:0], num_q[NW-1]};
            end
            num_q <= {num_q[NW-2:0], ~trial[DW]};
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 6'h01)
            begin
               busy_q <= 1'b0;
               done <= 1'b1;
               quot <= {num_q[NW-2:0], ~trial[DW]};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### agw_monitor.sv
/*
 Port checks for the auto gain window block.
 Assumes one clock, core_clk, and the async active-low reset rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agw_map.svh"
module agw_monitor
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   input wire logic pixFrameEnd,
   input wire logic [11:0] gainOut,
   input wire agw_pkg::agw_mode_type gainModeOut
);
   import agw_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic endSeen_q;
   logic [5:0] onceCnt_q;
   // Counts frame ends seen in once mode.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         endSeen_q <= 1'b0;
         onceCnt_q <= 6'h00;
      end
      else
      begin
         endSeen_q <= pixFrameEnd;
         if (gainModeOut != AGW_ONCE)
            onceCnt_q <= 6'h00;
         else if (pixFrameEnd && !endSeen_q)
            onceCnt_q <= onceCnt_q + 6'h01;
      end
   end
   a_read_idle_zero:
      assert property (!regRd |=> regRdata == 16'h0000) else $error("read data outside answer");
   a_unmapped_reads_zero:
      assert property (regRd && regAddr > `AGW_REG_GAIN_LIMITS |=> regRdata == 16'h0000)
      else $error("unmapped read not zero");
   a_target_floor:
      assert property (regWr && regAddr == `AGW_REG_TARGET && regWdata < 16'h0032 ##2
         regRd && regAddr == `AGW_REG_TARGET |=> regRdata == 16'h0032) else $error("target below floor");
   a_target_ceiling:
      assert property (regWr && regAddr == `AGW_REG_TARGET && regWdata > 16'h00CD ##2
         regRd && regAddr == `AGW_REG_TARGET |=> regRdata == 16'h00CD) else $error("target above ceiling");
   a_gain_single_step:
      assert property ($changed(gainOut) && !$past(regWr, 2) |->
         gainOut == $past(gainOut) + 12'h001 || gainOut == $past(gainOut) - 12'h001)
      else $error("gain jumped");
   a_off_holds_gain:
      assert property (gainModeOut == AGW_OFF && $past(gainModeOut) == AGW_OFF && !$past(regWr, 2)
         |-> $stable(gainOut)) else $error("gain moved while off");
   a_manual_gain_load:
      assert property (regWr && regAddr == `AGW_REG_GAIN_VALUE && gainModeOut == AGW_OFF
         |-> ##2 gainOut == $past(regWdata[11:0], 2)) else $error("manual gain not applied");
   a_once_frame_limit:
      assert property (onceCnt_q <= 6'h1E) else $error("once mode ran too long");
   a_mode_by_write:
      assert property ($changed(gainModeOut) && gainModeOut != AGW_OFF |->
         $past(regWr, 2) && $past(regAddr, 2) == `AGW_REG_GAIN_MODE) else $error("mode rose unasked");
endmodule
bind auto_gain_window_control agw_monitor u_agw_monitor (.core_clk, .rst_n, .regAddr, .regWdata, .regWr,
   .regRd, .regRdata, .pixFrameEnd, .gainOut, .gainModeOut);
`default_nettype wire

// ### auto_gain_window_control_tb.sv
/*
 Self-checking bench for the gain window block.
 Assumes the design and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agw_map.svh"
module auto_gain_window_control_tb;
   import agw_pkg::*;
   localparam logic [11:0] COLS = 12'h293;
   localparam logic [11:0] LINES = 12'h1EE;
   logic core_clk, rst_n, regWr, regRd, pixFrameStart, pixFrameEnd, pixLineStart, pixValid, pixWide;
   logic [7:0] regAddr;
   logic [15:0] regWdata, regRdata, v;
   logic [11:0] pixData, gainOut, gExp, hi;
   agw_mode_type gainModeOut;
   int errCount = 0;
   int checkCount = 0;
   auto_gain_window_control #(.SENSOR_COLS(COLS), .SENSOR_LINES(LINES)) u_auto_gain_window_control (.core_clk,
      .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .pixFrameStart, .pixFrameEnd, .pixLineStart,
      .pixValid, .pixWide, .pixData, .gainOut, .gainModeOut);
   // Free-running 50 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic reportAndStop();
      if (errCount == 0 && checkCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp)
      begin
         errCount++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      chk(name, regRdata, exp);
   endtask
   // Pixel strobes held three cycles for the synchroniser.
   task automatic hold(input logic [3:0] s, input logic [11:0] d);
      @(posedge core_clk);
      {pixFrameStart, pixFrameEnd, pixLineStart, pixValid} <= s;
      pixData <= d;
      repeat (3) @(posedge core_clk);
      {pixFrameStart, pixFrameEnd, pixLineStart, pixValid} <= 4'h0;
   endtask
   // Two lines of four pixels; only the first two of line zero sit in the window.
   task automatic frame(input logic [7:0] inV, input logic [7:0] outV);
      hold(4'h8, 12'h000);
      for (int i = 0; i < 8; i++)
      begin
         if (i == 4)
            hold(4'h2, 12'h000);
         hold(4'h1, pixWide ? {(i < 2 ? inV : outV), 4'h0} : {4'h0, (i < 2 ? inV : outV)});
      end
      hold(4'h4, 12'h000);
      repeat (60) @(posedge core_clk);
   endtask
   function automatic logic [11:0] stepGain(logic [11:0] g, logic [7:0] avg, logic [11:0] top);
      if (avg < 8'h80 && g < top)
         return g + 12'h001;
      if (avg > 8'h80 && g > 12'h000)
         return g - 12'h001;
      return g;
   endfunction
   // A hang counts as a mismatch.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errCount++;
      reportAndStop();
   end
   // Main sequence: reset values, register corners, then frames.
   initial
   begin
      logic [15:0] tgtTab [4] = '{16'h0031, 16'h0032, 16'h00CD, 16'h00CE};
      logic [15:0] cfgTab [3] = '{16'h0008, 16'h000A, 16'h0009};
      logic [15:0] limTab [3] = '{16'h0F00, 16'hFF00, 16'h1F00};
      {regWr, regRd, pixFrameStart, pixFrameEnd, pixLineStart, pixValid, pixWide} = 7'h00;
      regAddr = 8'h00;
      regWdata = 16'h0000;
      pixData = 12'h000;
      rst_n = 1'b0;
      void'($urandom(32'h304DB46C));
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         wr(`AGW_REG_WIN_SELECT, 16'(s));
         rc(`AGW_REG_COL_START, 16'h0000, "colStart");
         rc(`AGW_REG_LINE_START, 16'h0000, "lineStart");
         rc(`AGW_REG_COLS, {4'h0, COLS}, "cols");
         rc(`AGW_REG_LINES, {4'h0, LINES}, "lines");
      end
      rc(`AGW_REG_CONFIG, 16'h0008, "config");
      rc(8'h20, 16'h0000, "unmapped");
      wr(`AGW_REG_COL_START, 16'h0007);
      rc(`AGW_REG_COL_START, 16'h0007, "oddColStart");
      wr(`AGW_REG_WIN_SELECT, 16'h0000);
      rc(`AGW_REG_COL_START, 16'h0000, "oneColStart");
      for (int i = 0; i < 10; i++)
      begin
         v = (i < 4) ? tgtTab[i] : 16'($urandom_range(255));
         wr(`AGW_REG_TARGET, v);
         rc(`AGW_REG_TARGET, v < 16'h0032 ? 16'h0032 : (v > 16'h00CD ? 16'h00CD : v), "target");
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(`AGW_REG_CONFIG, cfgTab[i]);
         rc(`AGW_REG_GAIN_LIMITS, limTab[i], "limits");
      end
      wr(`AGW_REG_CONFIG, 16'h0008);
      wr(`AGW_REG_TARGET, 16'h0080);
      wr(`AGW_REG_GAIN_MAX, 16'h00FF);
      wr(`AGW_REG_COLS, 16'h0002);
      wr(`AGW_REG_LINES, 16'h0001);
      gExp = 12'($urandom_range(16, 64));
      wr(`AGW_REG_GAIN_VALUE, {4'h0, gExp});
      rc(`AGW_REG_GAIN_MODE, 16'h0000, "mode");
      chk("gainManual", {4'h0, gainOut}, {4'h0, gExp});
      wr(`AGW_REG_GAIN_MODE, 16'h0002);
      for (int i = 0; i < 4; i++)
      begin
         pixWide <= i[0];
         v = (i == 3) ? 16'h00C8 : 16'($urandom_range(50, 120));
         frame(v[7:0], 8'hFA);
         gExp = stepGain(gExp, v[7:0], 12'h0FF);
         chk("gainCont", {4'h0, gainOut}, {4'h0, gExp});
         rc(`AGW_REG_AVERAGE, v, "average");
      end
      wr(`AGW_REG_IMG_COLS, 16'h0010);
      wr(`AGW_REG_IMG_COL_START, 16'h0010);
      frame(8'h32, 8'h32);
      chk("gainNoOverlap", {4'h0, gainOut}, {4'h0, gExp});
      wr(`AGW_REG_IMG_COL_START, 16'h0000);
      wr(`AGW_REG_IMG_COLS, {4'h0, COLS});
      wr(`AGW_REG_GAIN_MODE, 16'h0000);
      frame(8'h32, 8'h32);
      chk("gainOff", {4'h0, gainOut}, {4'h0, gExp});
      wr(`AGW_REG_GAIN_MODE, 16'h0001);
      frame(8'h80, 8'h00);
      chk("onceReached", {14'h0, gainModeOut}, {14'h0, AGW_OFF});
      hi = gExp + 12'h003;
      wr(`AGW_REG_GAIN_MAX, {4'h0, hi});
      wr(`AGW_REG_GAIN_MODE, 16'h0001);
      for (int i = 1; i <= 30; i++)
      begin
         frame(8'h32, 8'h32);
         gExp = stepGain(gExp, 8'h32, hi);
         chk("onceGain", {4'h0, gainOut}, {4'h0, gExp});
         chk("onceMode", {14'h0, gainModeOut}, {14'h0, (i == 30) ? AGW_OFF : AGW_ONCE});
      end
      wr(`AGW_REG_CONFIG, 16'h000C);
      wr(`AGW_REG_GAIN_MODE, 16'h0001);
      rc(`AGW_REG_GAIN_MODE, 16'h0002, "profileMode");
      reportAndStop();
   end
endmodule
`default_nettype wire
